// >>> inc/rung_eval_pkg.sv
// package for the ladder boolean contact evaluator
// assumes one 200 MHz clock and a sequencer that issues one instruction per accepted request
// Function
// - or rung with true word bit
// - or rung with inverted word bit
// - and rung with true contact
// - and rung with inverted contact
// - and rung with true word bit
// - and rung with inverted word bit
// - and two latest branches; stack top with rung
// - or two latest branches together
// - coil write stores rung value
// - last coil write wins
// - word bit write keeps other bits
// - last word bit write wins
// - accumulating coil ors rung into coil
// - invert replaces rung by complement
// - eight level stack, overflow raises error
// - push shifts stack down, combines merge top
package rung_eval_pkg;
   localparam int STACK_DEPTH = 8;
   localparam int WORD_W = 16;
   localparam int BIT_IDX_W = 5;
   localparam int ADDR_W = 16;
   localparam logic [BIT_IDX_W-1:0] BIT_IDX_MAX = 5'h0f;
   localparam logic [3:0] DEPTH_MAX = 4'h8;
   // opcodes, width 5
   localparam logic [4:0] OP_NOP = 5'h00;
   localparam logic [4:0] OP_BRANCH_BEGIN_PUSH = 5'h01;
   localparam logic [4:0] OP_BRANCH_BEGIN_PUSH_INV = 5'h02;
   localparam logic [4:0] OP_PARALLEL_CONTACT = 5'h03;
   localparam logic [4:0] OP_PARALLEL_INVERTED_CONTACT = 5'h04;
   localparam logic [4:0] OP_OR_WORD_BIT_CONTACT = 5'h05;
   localparam logic [4:0] OP_OR_INVERTED_WORD_BIT_CONTACT = 5'h06;
   localparam logic [4:0] OP_SERIES_CONTACT = 5'h07;
   localparam logic [4:0] OP_SERIES_INVERTED_CONTACT = 5'h08;
   localparam logic [4:0] OP_SERIES_WORD_BIT_CONTACT = 5'h09;
   localparam logic [4:0] OP_SERIES_INVERTED_WORD_BIT_CONTACT = 5'h0a;
   localparam logic [4:0] OP_COMBINE_BRANCHES_SERIES = 5'h0b;
   localparam logic [4:0] OP_COMBINE_BRANCHES_PARALLEL = 5'h0c;
   localparam logic [4:0] OP_COIL_WRITE = 5'h0d;
   localparam logic [4:0] OP_WORD_BIT_COIL_WRITE = 5'h0e;
   localparam logic [4:0] OP_ACCUMULATING_COIL_WRITE = 5'h0f;
   localparam logic [4:0] OP_INVERT_RUNG = 5'h10;
   localparam logic [4:0] OP_RUNG_BEGIN = 5'h11;
   localparam logic [4:0] OP_RUNG_BEGIN_INV = 5'h12;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_FETCH = 3'b010,
      ST_EXEC = 3'b100
   } state_type;
endpackage

// >>> src/bit_stack.sv
// eight level boolean stack with shift push and top-with-rung merge
// assumes the caller never pushes and merges in the same cycle
`timescale 1ns/1ps
`default_nettype none
module bit_stack (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_clear,
   input wire logic i_push,
   input wire logic i_push_bit,
   input wire logic i_merge,
   input wire logic i_merge_is_and,
   input wire logic i_merge_rung,
   output logic o_top,
   output logic o_merged,
   output logic [3:0] o_depth
);
   logic [rung_eval_pkg::STACK_DEPTH-1:0] levels_ff, nxt_levels;
   logic [3:0] depth_ff, nxt_depth;
   logic merged;
   // ********************
   // stack update
   // ********************
   always_comb begin
      nxt_levels = levels_ff;
      nxt_depth = depth_ff;
      merged = i_merge_is_and ? (levels_ff[0] & i_merge_rung) : (levels_ff[0] | i_merge_rung);
      if (i_clear) begin
         nxt_levels = '0;
         nxt_depth = 4'h0;
      end else if (i_push) begin
         nxt_levels = {levels_ff[rung_eval_pkg::STACK_DEPTH-2:0], i_push_bit};
         nxt_depth = depth_ff + 4'h1;
      end else if (i_merge) begin
         // top level is popped; the merged value goes back to the rung
         nxt_levels = {1'b0, levels_ff[rung_eval_pkg::STACK_DEPTH-1:1]};
         nxt_depth = depth_ff - 4'h1;
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         levels_ff <= '0;
         depth_ff <= 4'h0;
      end else begin
         levels_ff <= nxt_levels;
         depth_ff <= nxt_depth;
      end
   end
   assign o_top = levels_ff[0];
   assign o_merged = merged;
   assign o_depth = depth_ff;
endmodule
`default_nettype wire

// >>> src/rung_eval.sv
// ladder rung boolean evaluator: contacts, branches, coils, invert
// assumes image and word memory answer a read one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module rung_eval (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_op_valid,
   output logic o_op_ready,
   input wire logic [4:0] i_op_code,
   input wire logic [rung_eval_pkg::ADDR_W-1:0] i_op_addr,
   input wire logic [rung_eval_pkg::BIT_IDX_W-1:0] i_op_bit,
   output logic o_rd_en,
   output logic [rung_eval_pkg::ADDR_W-1:0] o_rd_addr,
   input wire logic [rung_eval_pkg::WORD_W-1:0] i_rd_data,
   output logic o_wr_en,
   output logic [rung_eval_pkg::ADDR_W-1:0] o_wr_addr,
   output logic [rung_eval_pkg::WORD_W-1:0] o_wr_data,
   output logic o_rung,
   output logic o_done,
   output logic o_stack_err,
   output logic o_operand_err,
   output logic [3:0] o_depth
);
   rung_eval_pkg::state_type state_ff, nxt_state;
   logic [4:0] op_ff, nxt_op;
   logic [rung_eval_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
   logic [3:0] bit_ff, nxt_bit;
   logic rung_ff, nxt_rung;
   logic rd_en_ff, nxt_rd_en;
   logic wr_en_ff, nxt_wr_en;
   logic [rung_eval_pkg::ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
   logic [rung_eval_pkg::WORD_W-1:0] wr_data_ff, nxt_wr_data;
   logic done_ff, nxt_done;
   logic stack_err_ff, nxt_stack_err;
   logic operand_err_ff, nxt_operand_err;
   logic accept, needs_read, uses_bit, bad_bit;
   logic st_clear, st_push, st_push_bit, st_merge, st_merge_and;
   logic st_top, st_merged;
   logic [3:0] depth;
   logic contact, word_bit;
   // ********************
   // decode
   // ********************
   assign accept = i_op_valid && (state_ff == rung_eval_pkg::ST_IDLE);
   // only word-bit operations carry an index, so only they can fail on it
   assign uses_bit = (i_op_code == rung_eval_pkg::OP_OR_WORD_BIT_CONTACT) ||
                     (i_op_code == rung_eval_pkg::OP_OR_INVERTED_WORD_BIT_CONTACT) ||
                     (i_op_code == rung_eval_pkg::OP_SERIES_WORD_BIT_CONTACT) ||
                     (i_op_code == rung_eval_pkg::OP_SERIES_INVERTED_WORD_BIT_CONTACT) ||
                     (i_op_code == rung_eval_pkg::OP_WORD_BIT_COIL_WRITE);
   assign bad_bit = uses_bit && (i_op_bit > rung_eval_pkg::BIT_IDX_MAX);
   // merges, invert, nop and plain coil write skip the read; everything else reads first
   assign needs_read = !((i_op_code == rung_eval_pkg::OP_COMBINE_BRANCHES_SERIES) ||
                         (i_op_code == rung_eval_pkg::OP_COMBINE_BRANCHES_PARALLEL) ||
                         (i_op_code == rung_eval_pkg::OP_INVERT_RUNG) ||
                         (i_op_code == rung_eval_pkg::OP_COIL_WRITE) ||
                         (i_op_code == rung_eval_pkg::OP_NOP));
   assign word_bit = i_rd_data[bit_ff];
   assign contact = i_rd_data[0];
   // ********************
   // sequencer
   // ********************
   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_addr = addr_ff;
      nxt_bit = bit_ff;
      nxt_rung = rung_ff;
      nxt_rd_en = 1'b0;
      nxt_wr_en = 1'b0;
      nxt_wr_addr = wr_addr_ff;
      nxt_wr_data = wr_data_ff;
      nxt_done = 1'b0;
      nxt_stack_err = stack_err_ff;
      nxt_operand_err = operand_err_ff;
      st_clear = 1'b0;
      st_push = 1'b0;
      st_push_bit = 1'b0;
      st_merge = 1'b0;
      st_merge_and = 1'b0;
      case (state_ff)
         rung_eval_pkg::ST_IDLE: begin
            if (accept) begin
               nxt_op = i_op_code;
               nxt_addr = i_op_addr;
               nxt_bit = i_op_bit[3:0];
               if (i_op_code == rung_eval_pkg::OP_RUNG_BEGIN || i_op_code == rung_eval_pkg::OP_RUNG_BEGIN_INV) begin
                  st_clear = 1'b1;
                  nxt_rung = 1'b0;
                  nxt_stack_err = 1'b0;
                  nxt_operand_err = 1'b0;
               end
               if (bad_bit) begin
                  nxt_operand_err = 1'b1;
                  nxt_done = 1'b1;
               end else if (needs_read) begin
                  nxt_rd_en = 1'b1;
                  nxt_state = rung_eval_pkg::ST_FETCH;
               end else begin
                  nxt_state = rung_eval_pkg::ST_EXEC;
               end
            end
         end
         rung_eval_pkg::ST_FETCH: begin
            nxt_state = rung_eval_pkg::ST_EXEC;
         end
         rung_eval_pkg::ST_EXEC: begin
            nxt_state = rung_eval_pkg::ST_IDLE;
            nxt_done = 1'b1;
            case (op_ff)
               rung_eval_pkg::OP_RUNG_BEGIN: nxt_rung = contact;
               rung_eval_pkg::OP_RUNG_BEGIN_INV: nxt_rung = !contact;
               rung_eval_pkg::OP_BRANCH_BEGIN_PUSH, rung_eval_pkg::OP_BRANCH_BEGIN_PUSH_INV: begin
                  // current rung value sinks into the stack, new branch starts
                  if (depth == rung_eval_pkg::DEPTH_MAX) begin
                     nxt_stack_err = 1'b1;
                  end else begin
                     st_push = 1'b1;
                     st_push_bit = rung_ff;
                  end
                  nxt_rung = (op_ff == rung_eval_pkg::OP_BRANCH_BEGIN_PUSH) ? contact : !contact;
               end
               rung_eval_pkg::OP_PARALLEL_CONTACT: nxt_rung = rung_ff | contact;
               rung_eval_pkg::OP_PARALLEL_INVERTED_CONTACT: nxt_rung = rung_ff | !contact;
               rung_eval_pkg::OP_OR_WORD_BIT_CONTACT: nxt_rung = rung_ff | word_bit;
               rung_eval_pkg::OP_OR_INVERTED_WORD_BIT_CONTACT: nxt_rung = rung_ff | !word_bit;
               rung_eval_pkg::OP_SERIES_CONTACT: nxt_rung = rung_ff & contact;
               rung_eval_pkg::OP_SERIES_INVERTED_CONTACT: nxt_rung = rung_ff & !contact;
               rung_eval_pkg::OP_SERIES_WORD_BIT_CONTACT: nxt_rung = rung_ff & word_bit;
               rung_eval_pkg::OP_SERIES_INVERTED_WORD_BIT_CONTACT: nxt_rung = rung_ff & !word_bit;
               rung_eval_pkg::OP_COMBINE_BRANCHES_SERIES, rung_eval_pkg::OP_COMBINE_BRANCHES_PARALLEL: begin
                  if (depth == 4'h0) begin
                     nxt_stack_err = 1'b1;
                  end else begin
                     st_merge = 1'b1;
                     st_merge_and = (op_ff == rung_eval_pkg::OP_COMBINE_BRANCHES_SERIES);
                     nxt_rung = st_merged;
                  end
               end
               rung_eval_pkg::OP_COIL_WRITE: begin
                  // every write goes out in program order, so the last one wins
                  nxt_wr_en = 1'b1;
                  nxt_wr_addr = addr_ff;
                  nxt_wr_data = {{(rung_eval_pkg::WORD_W-1){1'b0}}, rung_ff};
               end
               rung_eval_pkg::OP_WORD_BIT_COIL_WRITE: begin
                  nxt_wr_en = 1'b1;
                  nxt_wr_addr = addr_ff;
                  nxt_wr_data = i_rd_data;
                  nxt_wr_data[bit_ff] = rung_ff;
               end
               rung_eval_pkg::OP_ACCUMULATING_COIL_WRITE: begin
                  nxt_wr_en = 1'b1;
                  nxt_wr_addr = addr_ff;
                  nxt_wr_data = {{(rung_eval_pkg::WORD_W-1){1'b0}}, rung_ff | contact};
               end
               rung_eval_pkg::OP_INVERT_RUNG: nxt_rung = !rung_ff;
               default: nxt_rung = rung_ff;
            endcase
         end
         default: nxt_state = rung_eval_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_ff <= rung_eval_pkg::ST_IDLE;
         op_ff <= rung_eval_pkg::OP_NOP;
         addr_ff <= '0;
         bit_ff <= 4'h0;
         rung_ff <= 1'b0;
         rd_en_ff <= 1'b0;
         wr_en_ff <= 1'b0;
         wr_addr_ff <= '0;
         wr_data_ff <= '0;
         done_ff <= 1'b0;
         stack_err_ff <= 1'b0;
         operand_err_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         addr_ff <= nxt_addr;
         bit_ff <= nxt_bit;
         rung_ff <= nxt_rung;
         rd_en_ff <= nxt_rd_en;
         wr_en_ff <= nxt_wr_en;
         wr_addr_ff <= nxt_wr_addr;
         wr_data_ff <= nxt_wr_data;
         done_ff <= nxt_done;
         stack_err_ff <= nxt_stack_err;
         operand_err_ff <= nxt_operand_err;
      end
   end
   bit_stack stack_u (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_clear(st_clear),
      .i_push(st_push),
      .i_push_bit(st_push_bit),
      .i_merge(st_merge),
      .i_merge_is_and(st_merge_and),
      .i_merge_rung(rung_ff),
      .o_top(st_top),
      .o_merged(st_merged),
      .o_depth(depth)
   );
   assign o_op_ready = (state_ff == rung_eval_pkg::ST_IDLE);
   assign o_rd_en = rd_en_ff;
   assign o_rd_addr = addr_ff;
   assign o_wr_en = wr_en_ff;
   assign o_wr_addr = wr_addr_ff;
   assign o_wr_data = wr_data_ff;
   assign o_rung = rung_ff;
   assign o_done = done_ff;
   assign o_stack_err = stack_err_ff;
   assign o_operand_err = operand_err_ff;
   assign o_depth = depth;
   // ********************
   // checks
   // ********************
   series_word_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (state_ff == rung_eval_pkg::ST_EXEC && op_ff == rung_eval_pkg::OP_SERIES_WORD_BIT_CONTACT)
      |=> rung_ff == ($past(rung_ff) & $past(word_bit)))
      else $error("series word bit result wrong");
   or_word_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (state_ff == rung_eval_pkg::ST_EXEC && op_ff == rung_eval_pkg::OP_OR_WORD_BIT_CONTACT)
      |=> rung_ff == ($past(rung_ff) | $past(word_bit)))
      else $error("or word bit result wrong");
   or_inv_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (state_ff == rung_eval_pkg::ST_EXEC && op_ff == rung_eval_pkg::OP_OR_INVERTED_WORD_BIT_CONTACT)
      |=> rung_ff == ($past(rung_ff) | !$past(word_bit)))
      else $error("or inverted word bit wrong");
   series_inv_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (state_ff == rung_eval_pkg::ST_EXEC && op_ff == rung_eval_pkg::OP_SERIES_INVERTED_CONTACT)
      |=> rung_ff == ($past(rung_ff) & !$past(contact)))
      else $error("series inverted contact wrong");
   invert_rung_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (state_ff == rung_eval_pkg::ST_EXEC && op_ff == rung_eval_pkg::OP_INVERT_RUNG) |=> rung_ff != $past(rung_ff))
      else $error("invert did not complement rung");
   coil_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (state_ff == rung_eval_pkg::ST_EXEC && op_ff == rung_eval_pkg::OP_COIL_WRITE)
      |=> o_wr_en && o_wr_data[0] == $past(rung_ff) ##1 !o_wr_en)
      else $error("coil write missing or wrong");
   bit_write_keep_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (state_ff == rung_eval_pkg::ST_EXEC && op_ff == rung_eval_pkg::OP_WORD_BIT_COIL_WRITE)
      |=> o_wr_en && ((o_wr_data ^ $past(i_rd_data)) & ~(16'h0001 << $past(bit_ff))) == 16'h0000)
      else $error("word bit write disturbed other bits");
   push_top_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (state_ff == rung_eval_pkg::ST_EXEC && st_push) |=> st_top == $past(rung_ff) && depth == $past(depth) + 4'h1)
      else $error("push did not land on stack top");
   stack_bound_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      depth <= rung_eval_pkg::DEPTH_MAX)
      else $error("stack depth above eight");
   bad_index_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (accept && bad_bit) |=> o_operand_err && o_done && !o_rd_en)
      else $error("bad bit index not rejected");
   new_rung_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (accept && i_op_code == rung_eval_pkg::OP_RUNG_BEGIN) |=> depth == 4'h0 ##1 depth == 4'h0)
      else $error("new rung did not clear stack");
endmodule
`default_nettype wire

// >>> verification/word_mem_model.sv
// image and word memory model facing the rung evaluator
// assumes addresses below 16; upper address bits are ignored
`timescale 1ns/1ps
`default_nettype none
module word_mem_model (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_rd_en,
   input wire logic [15:0] i_rd_addr,
   output logic [15:0] o_rd_data,
   input wire logic i_wr_en,
   input wire logic [15:0] i_wr_addr,
   input wire logic [15:0] i_wr_data
);
   // ************************************************************
   // storage and read port
   // ************************************************************
   logic [15:0] mem_ff [16];
   logic [1:0] hold_ff;
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int i = 0; i < 16; i++) begin
            mem_ff[i] <= {i[3:0], ~i[3:0], i[3:0], ~i[3:0]};
         end
         o_rd_data <= 16'h0000;
         hold_ff <= 2'h0;
      end else begin
         if (i_wr_en) begin
            mem_ff[i_wr_addr[3:0]] <= i_wr_data;
         end
         // data valid for three cycles, then toggles so a late sample cannot pass by luck
         if (i_rd_en) begin
            o_rd_data <= mem_ff[i_rd_addr[3:0]];
            hold_ff <= 2'h2;
         end else if (hold_ff != 2'h0) begin
            hold_ff <= hold_ff - 2'h1;
         end else begin
            o_rd_data <= ~o_rd_data;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb_ladder_boolean_contact_eval.sv
// self-checking bench for the rung evaluator
// assumes word_mem_model preloads word i with {i, ~i, i, ~i} nibbles
`timescale 1ns/1ps
`default_nettype none
module tb_ladder_boolean_contact_eval;
   // ************************************************************
   // signals, instances
   // ************************************************************
   typedef struct packed {
      logic [4:0] code;
      logic [15:0] addr;
      logic [4:0] bit_i;
      logic rung;
      logic [3:0] depth;
   } row_type;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic op_valid = 1'b0;
   logic [4:0] op_code = 5'h00;
   logic [15:0] op_addr = 16'h0000;
   logic [4:0] op_bit = 5'h00;
   logic op_ready, rd_en, wr_en, rung, done, stack_err, operand_err;
   logic [15:0] rd_addr, rd_data, wr_addr, wr_data;
   logic [3:0] depth;
   int error_cnt = 0;
   int num_checks = 0;
   always #2.5 sys_clk = ~sys_clk;
   rung_eval DUT (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_op_valid(op_valid), .o_op_ready(op_ready),
      .i_op_code(op_code), .i_op_addr(op_addr), .i_op_bit(op_bit), .o_rd_en(rd_en), .o_rd_addr(rd_addr),
      .i_rd_data(rd_data), .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rung(rung),
      .o_done(done), .o_stack_err(stack_err), .o_operand_err(operand_err), .o_depth(depth));
   word_mem_model mem (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
      .o_rd_data(rd_data), .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic conclude();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // wide enough that a strobe bit above a full word is never cut off
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // called at a falling edge; returns at the falling edge where done is seen
   task automatic exec(input logic [4:0] c, input logic [15:0] a, input logic [4:0] b);
      int n;
      n = 0;
      op_code = c;
      op_addr = a;
      op_bit = b;
      op_valid = 1'b1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      op_valid = 1'b0;
      while (done !== 1'b1 && n < 8) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 8) begin
         error_cnt++;
         conclude();
      end
   endtask
   // ************************************************************
   // table: two rungs through every contact and branch opcode
   // ************************************************************
   row_type rows [17] = '{
      '{rung_eval_pkg::OP_RUNG_BEGIN, 16'h0002, 5'h00, 1'b1, 4'h0},
      '{rung_eval_pkg::OP_SERIES_CONTACT, 16'h0003, 5'h00, 1'b0, 4'h0},
      '{rung_eval_pkg::OP_OR_WORD_BIT_CONTACT, 16'h0005, 5'h0c, 1'b1, 4'h0},
      '{rung_eval_pkg::OP_SERIES_INVERTED_CONTACT, 16'h0001, 5'h00, 1'b1, 4'h0},
      '{rung_eval_pkg::OP_SERIES_WORD_BIT_CONTACT, 16'h0005, 5'h0f, 1'b0, 4'h0},
      '{rung_eval_pkg::OP_OR_INVERTED_WORD_BIT_CONTACT, 16'h0005, 5'h0d, 1'b1, 4'h0},
      '{rung_eval_pkg::OP_SERIES_INVERTED_WORD_BIT_CONTACT, 16'h0005, 5'h01, 1'b0, 4'h0},
      '{rung_eval_pkg::OP_INVERT_RUNG, 16'h0000, 5'h00, 1'b1, 4'h0},
      '{rung_eval_pkg::OP_BRANCH_BEGIN_PUSH, 16'h0003, 5'h00, 1'b0, 4'h1},
      '{rung_eval_pkg::OP_BRANCH_BEGIN_PUSH_INV, 16'h0003, 5'h00, 1'b1, 4'h2},
      '{rung_eval_pkg::OP_COMBINE_BRANCHES_SERIES, 16'h0000, 5'h00, 1'b0, 4'h1},
      '{rung_eval_pkg::OP_COMBINE_BRANCHES_PARALLEL, 16'h0000, 5'h00, 1'b1, 4'h0},
      '{rung_eval_pkg::OP_RUNG_BEGIN_INV, 16'h0002, 5'h00, 1'b0, 4'h0},
      '{rung_eval_pkg::OP_PARALLEL_CONTACT, 16'h0003, 5'h00, 1'b0, 4'h0},
      '{rung_eval_pkg::OP_PARALLEL_INVERTED_CONTACT, 16'h0003, 5'h00, 1'b1, 4'h0},
      '{rung_eval_pkg::OP_SERIES_WORD_BIT_CONTACT, 16'h0005, 5'h00, 1'b0, 4'h0},
      '{rung_eval_pkg::OP_NOP, 16'h0000, 5'h00, 1'b0, 4'h0}
   };
   initial begin
      repeat (10) @(negedge sys_clk);
      chk({op_ready, rung, stack_err, operand_err, depth}, 16'h0080);
      rstn = 1'b1;
      @(negedge sys_clk);
      foreach (rows[i]) begin
         exec(rows[i].code, rows[i].addr, rows[i].bit_i);
         chk({rung, depth, stack_err, operand_err}, {rows[i].rung, rows[i].depth, 2'b00});
      end
      // coil writes: last one to a location wins
      exec(rung_eval_pkg::OP_RUNG_BEGIN_INV, 16'h0003, 5'h00);
      exec(rung_eval_pkg::OP_COIL_WRITE, 16'h0009, 5'h00);
      chk({wr_en, wr_addr, wr_data[0]}, {1'b1, 16'h0009, 1'b1});
      exec(rung_eval_pkg::OP_INVERT_RUNG, 16'h0000, 5'h00);
      exec(rung_eval_pkg::OP_COIL_WRITE, 16'h0009, 5'h00);
      chk({wr_en, wr_data[0]}, 2'b10);
      exec(rung_eval_pkg::OP_RUNG_BEGIN_INV, 16'h0009, 5'h00);
      chk(rung, 1'b1);
      // accumulating coil on word 9, now holding 0: 0, then 1, then stays 1
      exec(rung_eval_pkg::OP_INVERT_RUNG, 16'h0000, 5'h00);
      exec(rung_eval_pkg::OP_ACCUMULATING_COIL_WRITE, 16'h0009, 5'h00);
      chk({wr_en, wr_data[0]}, 2'b10);
      for (int k = 0; k < 2; k++) begin
         exec(rung_eval_pkg::OP_INVERT_RUNG, 16'h0000, 5'h00);
         exec(rung_eval_pkg::OP_ACCUMULATING_COIL_WRITE, 16'h0009, 5'h00);
         chk({wr_en, wr_data[0]}, 2'b11);
      end
      // word bit writes keep the other fifteen bits
      exec(rung_eval_pkg::OP_RUNG_BEGIN, 16'h0002, 5'h00);
      exec(rung_eval_pkg::OP_WORD_BIT_COIL_WRITE, 16'h0005, 5'h0f);
      chk({wr_en, wr_addr}, {1'b1, 16'h0005});
      chk(wr_data, 16'hda5a);
      exec(rung_eval_pkg::OP_INVERT_RUNG, 16'h0000, 5'h00);
      exec(rung_eval_pkg::OP_WORD_BIT_COIL_WRITE, 16'h0005, 5'h0f);
      chk(wr_data, 16'h5a5a);
      exec(rung_eval_pkg::OP_RUNG_BEGIN, 16'h0003, 5'h00);
      exec(rung_eval_pkg::OP_OR_WORD_BIT_CONTACT, 16'h0005, 5'h0f);
      chk(rung, 1'b0);
      // stack fills to eight, ninth push errs
      exec(rung_eval_pkg::OP_RUNG_BEGIN, 16'h0002, 5'h00);
      repeat (8) exec(rung_eval_pkg::OP_BRANCH_BEGIN_PUSH, 16'h0002, 5'h00);
      chk({stack_err, depth}, 5'h08);
      exec(rung_eval_pkg::OP_BRANCH_BEGIN_PUSH, 16'h0002, 5'h00);
      chk({stack_err, depth}, 5'h18);
      // bit index sixteen is refused, rung untouched
      exec(rung_eval_pkg::OP_SERIES_WORD_BIT_CONTACT, 16'h0005, 5'h10);
      chk({operand_err, rung}, 2'b11);
      exec(rung_eval_pkg::OP_RUNG_BEGIN, 16'h0003, 5'h00);
      chk({stack_err, operand_err, rung, depth}, 7'h00);
      // merge with nothing pushed errs and leaves rung and depth alone
      exec(rung_eval_pkg::OP_COMBINE_BRANCHES_PARALLEL, 16'h0000, 5'h00);
      chk({stack_err, depth, rung}, 6'h20);
      // reset in mid rung clears the stack
      exec(rung_eval_pkg::OP_BRANCH_BEGIN_PUSH, 16'h0002, 5'h00);
      rstn = 1'b0;
      @(negedge sys_clk);
      chk({op_ready, rung, stack_err, depth}, 7'h40);
      rstn = 1'b1;
      @(negedge sys_clk);
      // block must take work again after a mid-run reset
      exec(rung_eval_pkg::OP_RUNG_BEGIN, 16'h0002, 5'h00);
      chk({rung, depth, stack_err}, 6'h20);
      conclude();
   end
endmodule
`default_nettype wire
